// [hw/eprom_ctl_defines.vh]
/*
 Constants for the UV EPROM access controller: array geometry, pin mode
 encodings, delays in cycles of the 125 MHz CLOCK, programming limits.
 Assumes it is included by bare name from design files under hw/.
*/
`ifndef EPROM_CTL_DEFINES_VH
`define EPROM_CTL_DEFINES_VH

`define ADDR_W 19
`define DATA_W 8
`define LAST_ADDR 19'h7_FFFF
`define ERASED_BYTE 8'h_FF
`define CLK_NS 8
// Access delays in ns; defaults cover the slowest grade
`define ACC_NS 250
`define OE_NS 100
`define ACC_CYC ((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define OE_CYC ((`OE_NS + `CLK_NS - 1) / `CLK_NS)
// Address setup before gate falls: ACC - OE, at least one cycle
`define SETUP_CYC ((`ACC_CYC - `OE_CYC) > 0 ? (`ACC_CYC - `OE_CYC) : 1)
// Programming pulse, 100 us
`define PULSE_US 100
`define PULSE_CYC (`PULSE_US * 1000 / `CLK_NS)
`define MAX_PULSES 25
// Supply level codes driven on SUPPLY_MODE
`define SUP_READ 2'h0
`define SUP_PROG 2'h1
`define SUP_FINAL 2'h2
// Command codes
`define CMD_READ 2'h0
`define CMD_PROG 2'h1
`define CMD_IDENT 2'h2
`define CMD_FINAL 2'h3
// Auto-select address line positions
`define ID_TRIG_BIT 9
`define ID_SEL_BIT 0

`endif

// [hw/eprom_ctl.v]
/*
 Host-side controller for a byte-wide 512K x 8 UV EPROM: reads, auto-select
 identifier reads, pulse-and-verify programming of one byte, and the final
 verify of one byte at the final supply level. Assumes board switches raise the program voltage,
 core supply and identifier high voltage from PROG_VPP, SUPPLY_MODE and
 ID_HV, and that the data pins are shared tristate lines resolved outside.
*/
`timescale 1ns/10ps
`include "eprom_ctl_defines.vh"

module eprom_ctl (
    input wire CLOCK, // 125 MHz clock
    input wire RST, // Synchronous reset, active high
    input wire CE, // Clock enable, freezes all state when low
    input wire REQ_VALID, // Command request strobe
    input wire [1:0] REQ_CMD, // Command code
    input wire [18:0] REQ_ADDR, // Byte address, or id byte select in bit 0
    input wire [7:0] REQ_DATA, // Byte to program
    output reg REQ_READY, // Idle, command can be taken
    output reg RSP_VALID, // One-cycle answer pulse
    output reg [7:0] RSP_DATA, // Byte read or last read back
    output reg RSP_ERROR, // Verify mismatch, pulse limit or bad parity
    output reg [18:0] WORD_ADDRESS, // Address pins
    output reg CHIP_SELECT_PULSE_N, // Select and program pulse pin
    output reg OUTPUT_GATE_N, // Output gate pin
    input wire [7:0] DATA_LINES_IN, // Data pins, level seen
    output reg [7:0] DATA_LINES_OUT, // Data pins, driven value
    output reg DATA_LINES_OE, // High while controller drives data pins
    output reg PROG_VPP, // Raise program voltage
    output reg ID_HV, // Force identifier line to high voltage
    output reg [1:0] SUPPLY_MODE // Core supply level code
);

    localparam ST_IDLE = 3'd0;
    localparam ST_SETUP = 3'd1;
    localparam ST_ACCESS = 3'd2;
    localparam ST_PULSE = 3'd3;
    localparam ST_RECOVER = 3'd4;
    localparam ST_DONE = 3'd5;

    localparam [18:0] ONE_ADDR = 19'h0_0001;
    localparam [7:0] ONE_PULSE = 8'h01;
    localparam [7:0] PULSE_LIMIT = `MAX_PULSES;
    localparam [15:0] ACC_C = `ACC_CYC;
    localparam [15:0] SETUP_C = `SETUP_CYC;
    localparam [15:0] PULSE_C = `PULSE_CYC;
    localparam [15:0] ONE_C = 16'h0001;

    reg [2:0] state_reg;
    reg [1:0] cmd_reg;
    reg [7:0] data_reg;
    reg [15:0] cnt_reg;
    reg [7:0] pulses_reg;
    reg [7:0] sync1_reg, sync2_reg, sync3_reg;
    reg stable_reg;
    reg [7:0] cap_reg;
    reg odd_parity;
    reg [7:0] mism;

    // Three-stage capture of the pin data; a change counts once stages agree
    always @(posedge CLOCK) begin
        if (RST) begin
            sync1_reg <= `ERASED_BYTE;
            sync2_reg <= `ERASED_BYTE;
            sync3_reg <= `ERASED_BYTE;
            cap_reg <= `ERASED_BYTE;
        end else if (CE) begin
            sync1_reg <= DATA_LINES_IN;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg)
                cap_reg <= sync3_reg;
        end
    end

    // Only ones may turn into zeros, yet any bit that differs from the wanted byte is a miss
    always @* begin
        odd_parity = ^cap_reg;
        mism = data_reg ^ cap_reg;
        stable_reg = (sync2_reg == sync3_reg);
    end

    // Main sequencer; one command at a time
    always @(posedge CLOCK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            cmd_reg <= `CMD_READ;
            data_reg <= `ERASED_BYTE;
            cnt_reg <= 16'h0000;
            pulses_reg <= 8'h00;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_DATA <= 8'h00;
            RSP_ERROR <= 1'b0;
            WORD_ADDRESS <= 19'h0_0000;
            CHIP_SELECT_PULSE_N <= 1'b1;
            OUTPUT_GATE_N <= 1'b1;
            DATA_LINES_OUT <= 8'h00;
            DATA_LINES_OE <= 1'b0;
            PROG_VPP <= 1'b0;
            ID_HV <= 1'b0;
            SUPPLY_MODE <= `SUP_READ;
        end else if (CE) begin
            RSP_VALID <= 1'b0;
            case (state_reg)
            ST_IDLE: begin
                REQ_READY <= 1'b1;
                CHIP_SELECT_PULSE_N <= 1'b1;
                OUTPUT_GATE_N <= 1'b1;
                DATA_LINES_OE <= 1'b0;
                if (REQ_VALID && REQ_READY) begin
                    REQ_READY <= 1'b0;
                    cmd_reg <= REQ_CMD;
                    data_reg <= REQ_DATA;
                    pulses_reg <= 8'h00;
                    cnt_reg <= SETUP_C;
                    state_reg <= ST_SETUP;
                    if (REQ_CMD == `CMD_IDENT) begin
                        WORD_ADDRESS <= 19'h0_0000;
                        WORD_ADDRESS[`ID_SEL_BIT] <= REQ_ADDR[`ID_SEL_BIT];
                        ID_HV <= 1'b1;
                    end else begin
                        WORD_ADDRESS <= REQ_ADDR;
                        ID_HV <= 1'b0;
                    end
                    if (REQ_CMD == `CMD_PROG) begin
                        PROG_VPP <= 1'b1;
                        SUPPLY_MODE <= `SUP_PROG;
                        DATA_LINES_OUT <= REQ_DATA;
                        DATA_LINES_OE <= 1'b1;
                    end else if (REQ_CMD == `CMD_FINAL) begin
                        PROG_VPP <= 1'b0;
                        SUPPLY_MODE <= `SUP_FINAL;
                    end else begin
                        PROG_VPP <= 1'b0;
                        SUPPLY_MODE <= `SUP_READ;
                    end
                end
            end
            // Select falls SETUP_C cycles after the address is set; for reads the gate falls with it
            ST_SETUP: begin
                if (cnt_reg > ONE_C) begin
                    cnt_reg <= cnt_reg - ONE_C;
                end else if (cmd_reg == `CMD_PROG && DATA_LINES_OE) begin
                    CHIP_SELECT_PULSE_N <= 1'b0;
                    OUTPUT_GATE_N <= 1'b1;
                    pulses_reg <= pulses_reg + ONE_PULSE;
                    cnt_reg <= PULSE_C;
                    state_reg <= ST_PULSE;
                end else begin
                    CHIP_SELECT_PULSE_N <= 1'b0;
                    OUTPUT_GATE_N <= 1'b0;
                    cnt_reg <= ACC_C + 16'h0003;
                    state_reg <= ST_ACCESS;
                end
            end
            ST_PULSE: begin
                if (cnt_reg > ONE_C) begin
                    cnt_reg <= cnt_reg - ONE_C;
                end else begin
                    CHIP_SELECT_PULSE_N <= 1'b1;
                    DATA_LINES_OE <= 1'b0;
                    cnt_reg <= ONE_C;
                    state_reg <= ST_RECOVER;
                end
            end
            // One idle cycle so the bus is released before the gate falls
            ST_RECOVER: begin
                cnt_reg <= SETUP_C;
                state_reg <= ST_SETUP;
            end
            ST_ACCESS: begin
                // Wait until the agreed byte has also reached the capture stage
                if (cnt_reg > ONE_C || !stable_reg || cap_reg != sync3_reg) begin
                    if (cnt_reg > ONE_C)
                        cnt_reg <= cnt_reg - ONE_C;
                end else begin
                    CHIP_SELECT_PULSE_N <= 1'b1;
                    OUTPUT_GATE_N <= 1'b1;
                    RSP_DATA <= cap_reg;
                    if (cmd_reg == `CMD_PROG && mism != 8'h00 && pulses_reg < PULSE_LIMIT) begin
                        DATA_LINES_OUT <= data_reg;
                        DATA_LINES_OE <= 1'b1;
                        cnt_reg <= SETUP_C;
                        state_reg <= ST_SETUP;
                    end else begin
                        if (cmd_reg == `CMD_IDENT)
                            RSP_ERROR <= ~odd_parity;
                        else if (cmd_reg == `CMD_READ)
                            RSP_ERROR <= 1'b0;
                        else
                            RSP_ERROR <= (mism != 8'h00);
                        RSP_VALID <= 1'b1;
                        state_reg <= ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                PROG_VPP <= 1'b0;
                ID_HV <= 1'b0;
                if (cmd_reg != `CMD_PROG)
                    SUPPLY_MODE <= `SUP_READ;
                state_reg <= ST_IDLE;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
            endcase
        end
    end

endmodule // eprom_ctl

// [tb/eprom_ctl_checker.sv]
/* Pin timing checker for eprom_ctl.
 Assumes bind to eprom_ctl, defines header on the include path. */
`timescale 1ns/10ps
`include "eprom_ctl_defines.vh"
module eprom_ctl_checker (
    input wire CLOCK, // Clock
    input wire RST, // Sync reset
    input wire RSP_VALID, // Answer pulse
    input wire [18:0] WORD_ADDRESS, // Address pins
    input wire CHIP_SELECT_PULSE_N, // Select
    input wire OUTPUT_GATE_N, // Gate
    input wire DATA_LINES_OE, // Data drive
    input wire PROG_VPP, // Program voltage
    input wire ID_HV, // Id high voltage
    input wire [1:0] SUPPLY_MODE // Supply code
);
    reg [13:0] low_reg;
    reg [13:0] gate_reg;
    // Pulse and gate spans; counters clear whenever the pin idles
    always @(posedge CLOCK) begin
        low_reg <= (!CHIP_SELECT_PULSE_N && DATA_LINES_OE) ? low_reg + 14'h1 : 14'h0;
        gate_reg <= OUTPUT_GATE_N ? 14'h0 : gate_reg + 14'h1;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_drive_only_prog: assert property (DATA_LINES_OE |-> PROG_VPP && OUTPUT_GATE_N)
        else $error("Data driven outside program mode");
    a_pulse_length: assert property ($rose(CHIP_SELECT_PULSE_N) && $past(DATA_LINES_OE) |-> low_reg == `PULSE_CYC)
        else $error("Program pulse length wrong");
    a_verify_follows: assert property ($rose(CHIP_SELECT_PULSE_N) && $past(DATA_LINES_OE)
        |-> ##[1:40] (!CHIP_SELECT_PULSE_N && !OUTPUT_GATE_N && PROG_VPP))
        else $error("No verify after pulse");
    a_prog_supply: assert property (PROG_VPP |-> SUPPLY_MODE == `SUP_PROG)
        else $error("Core supply not at program level");
    a_id_lines_low: assert property (ID_HV |-> (WORD_ADDRESS & 19'h7_FDFE) == 19'h0)
        else $error("Address lines not low in auto-select");
    a_gate_span: assert property ($rose(OUTPUT_GATE_N) |-> gate_reg >= `ACC_CYC)
        else $error("Gate closed before data valid");
    a_addr_steady: assert property (!CHIP_SELECT_PULSE_N && $past(!CHIP_SELECT_PULSE_N) |-> $stable(WORD_ADDRESS))
        else $error("Address moved while selected");
    a_gate_with_select: assert property (!OUTPUT_GATE_N |-> !CHIP_SELECT_PULSE_N)
        else $error("Gate open without select");
    c_answer: cover property (RSP_VALID);
    c_ident: cover property (ID_HV && !OUTPUT_GATE_N);
    c_pulse: cover property ($rose(CHIP_SELECT_PULSE_N) && $past(DATA_LINES_OE));
endmodule // eprom_ctl_checker
bind eprom_ctl eprom_ctl_checker u_chk (.CLOCK(CLOCK), .RST(RST), .RSP_VALID(RSP_VALID),
    .WORD_ADDRESS(WORD_ADDRESS), .CHIP_SELECT_PULSE_N(CHIP_SELECT_PULSE_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
    .DATA_LINES_OE(DATA_LINES_OE), .PROG_VPP(PROG_VPP), .ID_HV(ID_HV), .SUPPLY_MODE(SUPPLY_MODE));

// [tb/eprom_model.sv]
/* Behavioural 512K x 8 UV EPROM.
 Assumes the bench resolves the shared data pins from dq_en. */
`timescale 1ns/10ps
`include "eprom_ctl_defines.vh"
module eprom_model #(
    parameter [7:0] MAKER_ID = 8'h02, // Arbitrary value
    parameter [7:0] DEVICE_ID = 8'h07 // Arbitrary value
) (
    input wire [18:0] addr, // Address pins
    input wire sel_n, // Select and pulse
    input wire gate_n, // Output gate
    input wire vpp, // Program voltage
    input wire id_hv, // Id line at high voltage
    input wire [7:0] dq_in, // Pin level
    output wire [7:0] dq_out, // Driven byte
    output wire dq_en // Driving
);
    logic [7:0] mem [logic [18:0]];
    logic [7:0] cap;
    logic [7:0] val;
    int pulses = 0;
    logic arm = 1'b0;
    // Erased cells read one; a pulse only clears bits
    function automatic [7:0] rd(input [18:0] a);
        rd = mem.exists(a) ? mem[a] : `ERASED_BYTE;
    endfunction
    // Capture at pulse start, write at its end; select high inhibits
    // Pins settle before arming, so a verify opening gate and select together never programs
    always @(negedge sel_n) begin
        #1;
        arm = vpp && gate_n && !sel_n;
        cap = dq_in;
    end
    always @(posedge sel_n) begin
        if (arm && vpp) begin
            mem[addr] = rd(addr) & cap;
            pulses++;
        end
        arm = 1'b0;
    end
    always @(sel_n, gate_n, addr, id_hv, pulses) val = id_hv ? (addr[0] ? DEVICE_ID : MAKER_ID) : rd(addr);
    // Outputs only with select and gate low, after the access time
    assign #(`ACC_NS, 0) dq_en = !sel_n && !gate_n;
    assign dq_out = val;
endmodule // eprom_model

// [tb/test_uv_eprom_access_modes.sv]
/* Bench for eprom_ctl against a behavioural EPROM.
 Assumes the defines header on the include path. */
`timescale 1ns/10ps
`include "eprom_ctl_defines.vh"
module test_uv_eprom_access_modes;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg req_valid = 1'b0;
    reg [1:0] req_cmd = 2'h0;
    reg [18:0] req_addr = 19'h0;
    reg [7:0] req_data = 8'h0;
    reg [7:0] last_reg = 8'h0;
    wire req_ready, rsp_valid, rsp_error, sel_n, gate_n, oe, vpp, id_hv, m_en;
    wire [7:0] rsp_data, d_out, m_dq, d_in;
    wire [18:0] addr;
    wire [1:0] sup;
    logic [7:0] d;
    logic e;
    int n_fail = 0;
    int num_checks = 0;
    always #4 clock = ~clock;
    // Released pins show the inverse of the last level
    assign d_in = oe ? d_out : (m_en ? m_dq : ~last_reg);
    always @(posedge clock) last_reg <= d_in;
    eprom_ctl uut (.CLOCK(clock), .RST(rst), .CE(1'b1), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
        .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .RSP_ERROR(rsp_error), .WORD_ADDRESS(addr), .CHIP_SELECT_PULSE_N(sel_n),
        .OUTPUT_GATE_N(gate_n), .DATA_LINES_IN(d_in), .DATA_LINES_OUT(d_out), .DATA_LINES_OE(oe),
        .PROG_VPP(vpp), .ID_HV(id_hv), .SUPPLY_MODE(sup));
    eprom_model #(.MAKER_ID(8'h02), .DEVICE_ID(8'h07)) mdl (.addr(addr), .sel_n(sel_n), .gate_n(gate_n),
        .vpp(vpp), .id_hv(id_hv), .dq_in(d_in), .dq_out(m_dq), .dq_en(m_en));
    task check(input [7:0] seen, input [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One command; request held until taken, answer taken in its cycle
    task do_cmd(input [1:0] c, input [18:0] a, input [7:0] x);
        int n;
        @(posedge clock);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        req_data <= x;
        n = 0;
        @(posedge clock);
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 40000) n_fail++;
        d = rsp_data;
        e = rsp_error;
    endtask
    task t_erased;
        do_cmd(`CMD_READ, `LAST_ADDR, 8'h00);
        check(d, `ERASED_BYTE);
        check(e, 1'b0);
        check(m_en, 1'b0);
    endtask
    task t_ident;
        for (int i = 0; i < 2; i++) begin
            do_cmd(`CMD_IDENT, 19'(i), 8'h00);
            check(d, i ? 8'h07 : 8'h02);
            check(^d, 1'b1);
            check(e, 1'b0);
        end
    endtask
    task t_program;
        do_cmd(`CMD_PROG, 19'h0_0123, 8'hA5);
        check(d, 8'hA5);
        check(e, 1'b0);
        check(mdl.pulses[7:0], 8'h01);
        check(sup, `SUP_PROG);
        do_cmd(`CMD_PROG, 19'h0_0123, 8'h21);
        check(mdl.pulses[7:0], 8'h02);
        do_cmd(`CMD_READ, 19'h0_0123, 8'h00);
        check(d, 8'h21);
        do_cmd(`CMD_READ, 19'h0_0124, 8'h00);
        check(d, `ERASED_BYTE);
        do_cmd(`CMD_FINAL, 19'h0_0123, 8'h21);
        check(e, 1'b0);
        do_cmd(`CMD_FINAL, 19'h0_0123, 8'hA5);
        check(e, 1'b1);
        check(sup, `SUP_FINAL);
        check(m_en, 1'b0);
    endtask
    task wrap_up;
        $display("Checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog sized well above two program commands
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_erased;
        t_ident;
        t_program;
        wrap_up;
    end
endmodule // test_uv_eprom_access_modes
